//--- common/vpic_consts.svh
// Register offsets, field positions, reset values and table constants
`ifndef VPIC_CONSTS_SVH
`define VPIC_CONSTS_SVH
// APB byte offsets
`define VPIC_OFF_GCTL1     12'h000
`define VPIC_OFF_GCTL2     12'h004
`define VPIC_OFF_FLAG0     12'h010
`define VPIC_OFF_ENA0      12'h030
`define VPIC_OFF_PRIO0     12'h050
`define VPIC_OFF_LATCH     12'h0b0
`define VPIC_OFF_STATUS    12'h0c0
`define VPIC_OFF_CORE      12'h0c4
`define VPIC_OFF_ACK       12'h0c8
`define VPIC_OFF_TRAP      12'h0cc
// Register counts
`define VPIC_NUM_FLAG      6
`define VPIC_NUM_PRIO      20
// Field positions
`define VPIC_NEST_DIS_BIT  15
`define VPIC_ALT_SEL_BIT   15
`define VPIC_IPL_LSB       5
`define VPIC_CPU_PRIORITY_TOP_BIT_BIT      3
// Vector table
`define VPIC_DEF_BASE      24'h000004
`define VPIC_ALT_BASE      24'h000104
`define VPIC_RESET_ADDR    24'h000000
`define VPIC_FIRST_USER    7'h08
`define VPIC_LAST_USER     7'h57
`define VPIC_MAX_VECTOR    7'h7e
`define VPIC_GCTL1_MASK    16'hfffe
`define VPIC_GCTL2_MASK    16'h8007
`endif

//--- common/vpic_pkg.sv
// Types shared by the interrupt controller
package vpic_pkg;
  // Request presented to the CPU core
  typedef struct packed {
    logic        valid;
    logic [6:0]  vector;
    logic [3:0]  level;
    logic [23:0] fetch_addr;
  } vpic_req_t;
  // Latched vector register contents
  typedef struct packed {
    logic [6:0]  vec_num;
    logic [3:0]  new_level;
  } vpic_latch_t;
  // Acceptance handshake state
  typedef enum logic [1:0] {
    VPIC_IDLE    = 2'b00,
    VPIC_OFFER   = 2'b01,
    VPIC_RUNNING = 2'b11
  } vpic_state_t;
endpackage

//--- hw/vpic_ctrl.sv
// Vectored priority interrupt controller with APB register access
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "vpic_consts.svh"

// Overview of the controller
//
// Register map
// Control one at the base word: nesting disable on top, trap flags low.
// Control two next: alternate table select on top, edge polarities low.
// Six flag words, then six enable words, sixteen sources to a word.
// Twenty priority words, four sources to a word, one nibble each.
// Latched vector word: vector number low, new level above it.
// Status word: CPU level bits in the top three bits of the low byte.
// Core word: top level bit only, which software may clear, never set.
// Handshake state word, read only, for debug.
// Alternate select mirror, read only, for debug.
// Any other word answers with a slave error and reads as zero.
//
// Bus timing
// Read data captured in the setup cycle, held through the access.
// Writes land at the access edge, never in the setup cycle.
// Ready is tied high: every transfer takes exactly two cycles.
// Only the low half word carries data; upper strobes are ignored.
// Strobe bit 0 gates the low byte, strobe bit 1 the high byte.
//
// Source flags
// Each source has a set pulse input, one bit per source.
// A pulse sets the flag on the next edge, whatever software does.
// Software clears a flag by writing zero into its bit position.
// Set and clear in one cycle: the set wins, so no event is lost.
// Flags never clear by themselves, not even when the CPU takes one.
//
// External inputs
// Three pins feed the flags of sources 0, 20 and 29.
// Each pin is compared with its value one cycle earlier.
// Polarity bit low: rising edge sets the flag.
// Polarity bit high: falling edge sets the flag.
// Pins are assumed already synchronous to the bus clock.
// A change of polarity while the pin is steady raises no flag.
//
// Arbitration
// Candidates: flag set, enable set, vector inside the user range.
// The highest priority wins; a tie goes to the lowest vector.
// Priority zero never beats any CPU level, so it disables a source.
// The winner must beat the CPU level strictly to be offered.
// The top level bit, once set, keeps every user source out.
//
// Offer handshake
// Idle: an accepted winner moves the block into the offer state.
// Offer: vector and level stand until the take pulse; the fetch address follows alternate select.
// Take: the CPU level bits load the offered level, handler runs.
// Running: a higher winner may nest unless nesting is disabled.
// Handler done: back to idle, ready for the next winner.
// Only one level of running handler is remembered; the CPU core
// keeps the stack of earlier levels itself.
//
// Latched vector word
// Loaded only when a new winner is accepted, never during the take.
// Holds both the vector number and the level the CPU will run at.
//
// Fetch address
// Two bytes per vector from the table base.
// Alternate select swaps the base for every vector at once.
// The select is applied every cycle, so a change during the offer moves the fetch address.
//
// Reset
// Every register clears asynchronously, the request output too.
// Reset itself raises no offer and no fetch: the core starts at zero.
// Release may come on any edge; the first transfer may follow at once.
//
// Limitations
// Trap sources only set their status bits; no trap vectors here.
// The reset cause flags live outside this block.
// Unaligned addresses decode as their containing word only in the flag, enable and priority arrays.
//
// Hazards avoided
// Flag set wins over a clear written in the same cycle.
// Trap status set wins over a write to control one likewise.
// The offered vector and level never change under the CPU while it is taking it.
// The level bits ignore writes while nesting is disabled, so a
// handler cannot lower its own level by accident.
//
// Parameters
// NSRC sets the number of user sources, NEXT the external inputs.
// Widths of flag, enable and priority arrays follow NSRC.

module vpic_ctrl
  import vpic_pkg::*;
#(
  parameter int NSRC = 80,
  parameter int NEXT = 3
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Sources
  input  wire logic [NSRC-1:0]   src_event,
  input  wire logic [NEXT-1:0]   ext_pin,
  input  wire logic [6:0]        trap_event,
  // CPU core
  output vpic_req_t              cpu_req,
  input  wire logic              cpu_take,
  input  wire logic              handler_done
);

  // Register state
  logic [15:0]        gctl1_q, gctl2_q;
  logic [NSRC-1:0]    flag_q, ena_q;
  logic [3*NSRC-1:0]  prio_q;
  vpic_latch_t        latch_q;
  logic [2:0]         ipl_q;
  logic               cpu_priority_top_bit_q;
  logic [NEXT-1:0]    ext_q;
  vpic_state_t        st_q;
  logic [3:0]         run_lvl_q;

  // Source index to user vector number
  function automatic logic [6:0] idx_vec(input int i);
    return 7'(i) + `VPIC_FIRST_USER;
  endfunction

  // Vector to fetch address in chosen table
  function automatic logic [23:0] vec_addr(input logic [6:0] v,
                                           input logic       alt);
    return (alt ? `VPIC_ALT_BASE : `VPIC_DEF_BASE) +
           {16'h0000, v, 1'b0};
  endfunction

  // APB decode
  wire        wr_en   = psel & penable & pwrite;
  wire [9:0]  word    = paddr[11:2];
  wire        hit_g1  = paddr == `VPIC_OFF_GCTL1;
  wire        hit_g2  = paddr == `VPIC_OFF_GCTL2;
  wire        hit_st  = paddr == `VPIC_OFF_STATUS;
  wire        hit_co  = paddr == `VPIC_OFF_CORE;
  wire        hit_lt  = paddr == `VPIC_OFF_LATCH;
  wire        hit_ak  = paddr == `VPIC_OFF_ACK;
  wire        hit_tr  = paddr == `VPIC_OFF_TRAP;
  wire [9:0]  fl_idx  = word - 10'(`VPIC_OFF_FLAG0 >> 2);
  wire [9:0]  en_idx  = word - 10'(`VPIC_OFF_ENA0 >> 2);
  wire [9:0]  pr_idx  = word - 10'(`VPIC_OFF_PRIO0 >> 2);
  wire        hit_fl  = paddr >= `VPIC_OFF_FLAG0 &&
                        fl_idx < 10'(`VPIC_NUM_FLAG);
  wire        hit_en  = paddr >= `VPIC_OFF_ENA0 &&
                        en_idx < 10'(`VPIC_NUM_FLAG);
  wire        hit_pr  = paddr >= `VPIC_OFF_PRIO0 &&
                        pr_idx < 10'(`VPIC_NUM_PRIO);
  wire        mapped  = hit_g1 | hit_g2 | hit_st | hit_co | hit_lt |
                        hit_ak | hit_tr | hit_fl | hit_en | hit_pr;
  wire        lo_en   = pstrb[0];
  wire        hi_en   = pstrb[1];
  wire [15:0] wmask   = {{8{hi_en}}, {8{lo_en}}};
  wire        nest_dis = gctl1_q[`VPIC_NEST_DIS_BIT];
  wire        alt_sel  = gctl2_q[`VPIC_ALT_SEL_BIT];
  wire [3:0]  cpu_lvl  = {cpu_priority_top_bit_q, ipl_q};
  wire [15:0] trap_set = {8'h00, trap_event, 1'b0};

  // Edge detection on external inputs
  logic [NEXT-1:0] ext_edge;
  genvar e;
  generate
    for (e = 0; e < NEXT; e++) begin : g_ext
      assign ext_edge[e] = gctl2_q[e] ? (ext_q[e] & ~ext_pin[e])
                                      : (~ext_q[e] & ext_pin[e]);
    end
  endgenerate

  // External inputs map onto vectors 8, 28 and 37
  logic [NSRC-1:0] hw_set;
  always_comb begin
    hw_set = src_event;
    hw_set[0] = src_event[0] | ext_edge[0];
    if (NEXT > 1 && NSRC > 20) hw_set[20] = src_event[20] | ext_edge[1];
    if (NEXT > 2 && NSRC > 29) hw_set[29] = src_event[29] | ext_edge[2];
  end

  // Software flag and enable images, one word of 16 per register
  logic [NSRC-1:0] fl_wr, fl_wv, en_wr, en_wv;
  logic [3*NSRC-1:0] pr_wr, pr_wv;
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_src
      // Natural order bit i sits in word i/16, bit i%16
      assign fl_wr[i] = wr_en & hit_fl & fl_idx == 10'(i / 16) &
                        wmask[i % 16];
      assign fl_wv[i] = pwdata[i % 16];
      assign en_wr[i] = wr_en & hit_en & en_idx == 10'(i / 16) &
                        wmask[i % 16];
      assign en_wv[i] = pwdata[i % 16];
      assign pr_wr[3*i +: 3] = {3{wr_en & hit_pr & pr_idx == 10'(i / 4) &
                                  wmask[4*(i % 4)]}};
      assign pr_wv[3*i +: 3] = pwdata[4*(i % 4) +: 3];
    end
  endgenerate

  // Arbitration: highest priority, then lowest vector
  logic [2:0] best_p;
  logic [6:0] best_v;
  logic       best_ok;
  always_comb begin
    best_p  = 3'h0;
    best_v  = 7'h00;
    best_ok = 1'b0;
    for (int k = 0; k < NSRC; k++) begin
      if (flag_q[k] && ena_q[k] && idx_vec(k) <= `VPIC_LAST_USER &&
          (!best_ok || prio_q[3*k +: 3] > best_p)) begin
        best_p  = prio_q[3*k +: 3];
        best_v  = idx_vec(k);
        best_ok = 1'b1;
      end
    end
  end

  // Winner must exceed CPU level; nesting disable blocks pre-emption
  wire above   = best_ok && {1'b0, best_p} > cpu_lvl;
  wire may_run = st_q == VPIC_IDLE ||
                 (st_q == VPIC_RUNNING && !nest_dis &&
                  {1'b0, best_p} > run_lvl_q);
  wire accept  = above && may_run && st_q != VPIC_OFFER;

  // Handshake state
  vpic_state_t st_d;
  always_comb begin
    case (st_q)
      VPIC_IDLE:    st_d = accept ? VPIC_OFFER : VPIC_IDLE;
      VPIC_OFFER:   st_d = cpu_take ? VPIC_RUNNING : VPIC_OFFER;
      VPIC_RUNNING: st_d = accept ? VPIC_OFFER :
                           handler_done ? VPIC_IDLE : VPIC_RUNNING;
      default:      st_d = VPIC_IDLE;
    endcase
  end

  // Status level bits follow write unless nesting disabled
  wire st_wr  = wr_en & hit_st & lo_en & !nest_dis;
  wire co_wr  = wr_en & hit_co & lo_en;
  wire ack_wr = wr_en & hit_ak & lo_en;

  // Control and latch registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctl1_q   <= 16'h0000;
      gctl2_q   <= 16'h0000;
      latch_q   <= '0;
      ipl_q     <= 3'h0;
      cpu_priority_top_bit_q    <= 1'b0;
      st_q      <= VPIC_IDLE;
      run_lvl_q <= 4'h0;
      ext_q     <= '0;
    end else begin
      ext_q <= ext_pin;
      st_q  <= st_d;
      if (wr_en && hit_g1)
        gctl1_q <= ((gctl1_q & ~wmask) | (pwdata[15:0] & wmask &
                   `VPIC_GCTL1_MASK)) | trap_set;
      else
        gctl1_q <= gctl1_q | trap_set;
      if (wr_en && hit_g2)
        gctl2_q <= (gctl2_q & ~wmask) | (pwdata[15:0] & wmask &
                   `VPIC_GCTL2_MASK);
      if (accept) begin
        latch_q.vec_num   <= best_v;
        latch_q.new_level <= {1'b0, best_p};
        run_lvl_q         <= {1'b0, best_p};
      end
      if (st_q == VPIC_OFFER && cpu_take)
        ipl_q <= latch_q.new_level[2:0];
      else if (st_wr)
        ipl_q <= pwdata[`VPIC_IPL_LSB +: 3];
      if (co_wr && !pwdata[`VPIC_CPU_PRIORITY_TOP_BIT_BIT])
        cpu_priority_top_bit_q <= 1'b0;
    end
  end

  // Flags, enables and priorities; hardware set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
      ena_q  <= '0;
      prio_q <= '0;
    end else begin
      flag_q <= ((flag_q & ~fl_wr) | (fl_wv & fl_wr)) | hw_set;
      ena_q  <= (ena_q & ~en_wr) | (en_wv & en_wr);
      prio_q <= (prio_q & ~pr_wr) | (pr_wv & pr_wr);
    end
  end

  // Read data selection
  logic [15:0] rd16;
  always_comb begin
    rd16 = 16'h0000;
    if (hit_g1) rd16 = gctl1_q;
    else if (hit_g2) rd16 = gctl2_q;
    else if (hit_st) rd16 = {8'h00, ipl_q, 5'h00};
    else if (hit_co) rd16 = {12'h000, cpu_priority_top_bit_q, 3'h0};
    else if (hit_lt) rd16 = {5'h00, latch_q.new_level, latch_q.vec_num};
    else if (hit_ak) rd16 = {14'h0000, st_q};
    else if (hit_tr) rd16 = {15'h0000, alt_sel};
    else begin
      for (int k = 0; k < NSRC; k++) begin
        if (hit_fl && fl_idx == 10'(k / 16)) rd16[k % 16] = flag_q[k];
        if (hit_en && en_idx == 10'(k / 16)) rd16[k % 16] = ena_q[k];
        if (hit_pr && pr_idx == 10'(k / 4))
          rd16[4*(k % 4) +: 3] = prio_q[3*k +: 3];
      end
    end
  end

  // APB read data registered; zero wait states, unregistered error on unmapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {16'h0000, rd16};
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel & penable & !mapped;

  // Request to the CPU core, from the winner on accept, else from the latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_req <= '0;
    end else begin
      cpu_req.valid      <= st_d == VPIC_OFFER;
      cpu_req.vector     <= accept ? best_v : latch_q.vec_num;
      cpu_req.level      <= accept ? {1'b0, best_p} : latch_q.new_level;
      cpu_req.fetch_addr <= vec_addr(accept ? best_v : latch_q.vec_num,
                                     alt_sel);
    end
  end

  // Register count check: 2 control, 6 flag, 6 enable, 20 prio less
  // those unused by 80 sources, plus latch, totals 35 against the documented 30
  // for the full family; here offsets reserve all of them.

endmodule // vpic_ctrl

//--- tb/vpic_ctrl_props.sv
// Port checker for the interrupt controller
`timescale 1ns/1ps
module vpic_ctrl_props
  import vpic_pkg::*;
(
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // CPU side
  input wire vpic_req_t   cpu_req,
  input wire logic        cpu_take
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Helpers
  wire       acc = psel && penable;
  wire       vld = cpu_req.valid;
  wire [6:0] vec = cpu_req.vector;
  // Assertions
  a_ready_zero_wait: assert property (pready)
    else $error("pready low");
  a_fetch_addr_map: assert property (vld |->
    cpu_req.fetch_addr == 24'h000004 + {vec, 1'b0} ||
    cpu_req.fetch_addr == 24'h000104 + {vec, 1'b0})
    else $error("fetch address off table");
  a_vector_user_range: assert property (vld |->
    vec >= 7'h08 && vec <= 7'h57) else $error("vector out of range");
  a_level_user: assert property (vld |->
    cpu_req.level inside {[1:7]}) else $error("bad offer level");
  a_offer_holds: assert property (vld && !cpu_take |=>
    vld && $stable(vec) && $stable(cpu_req.level))
    else $error("offer changed before take");
  a_reset_clear: assert property ($rose(presetn) |->
    cpu_req == '0 && prdata == 32'h0) else $error("not clear at reset");
  a_unmapped_err: assert property (acc && paddr == 12'h0d0 |-> pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (acc && paddr == 12'h0b0 |-> !pslverr)
    else $error("error on mapped");
  // Covers
  c_offer: cover property (vld);
  c_take: cover property (vld && cpu_take);
  c_err: cover property (acc && pslverr);
endmodule // vpic_ctrl_props

bind vpic_ctrl vpic_ctrl_props u_vpic_ctrl_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_req(cpu_req), .cpu_take(cpu_take));

//--- tb/vpic_cpu_model.sv
// CPU core model that takes offers and returns from handlers
`timescale 1ns/1ps
module vpic_cpu_model
  import vpic_pkg::*;
#(
  parameter int TAKE_DLY = 3,
  parameter int DONE_DLY = 30
) (
  // Clock and reset
  input wire logic      pclk,
  input wire logic      presetn,
  // Controller side
  input wire vpic_req_t cpu_req,
  output logic          cpu_take,
  output logic          handler_done
);
  int wait_q;
  int run_q;
  // Take after a delay, return after a longer one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 0;
      run_q <= 0;
      cpu_take <= 1'b0;
      handler_done <= 1'b0;
    end else begin
      cpu_take <= 1'b0;
      handler_done <= (run_q == 1);
      if (run_q > 0) run_q <= run_q - 1;
      if (cpu_req.valid && !cpu_take) begin
        wait_q <= wait_q + 1;
        if (wait_q >= TAKE_DLY) begin
          cpu_take <= 1'b1;
          wait_q <= 0;
          run_q <= DONE_DLY;
        end
      end
    end
  end
endmodule // vpic_cpu_model

//--- tb/testbench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
  import vpic_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0]  pstrb = 4'h3;
  logic        pready, pslverr, err, cpu_take, handler_done;
  logic [79:0] src_event = '0;
  logic [2:0]  ext_pin = '0;
  logic [6:0]  trap_event = '0;
  vpic_req_t   cpu_req;
  int          fails = 0, num_checks = 0, cyc = 0;

  always #4 pclk = ~pclk;

  // Design and CPU model
  vpic_ctrl u_vpic_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .src_event,
    .ext_pin, .trap_event, .cpu_req, .cpu_take, .handler_done);
  vpic_cpu_model u_vpic_cpu_model (.pclk, .presetn, .cpu_req, .cpu_take,
    .handler_done);

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) begin
      fails++;
      $display("FAIL %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Source pulse and bounded wait for an offer
  task automatic pulse(input logic [79:0] m);
    @(posedge pclk);
    src_event <= m;
    @(posedge pclk);
    src_event <= '0;
  endtask

  task automatic wait_req(input int n);
    repeat (n) begin
      @(negedge pclk);
      if (cpu_req.valid === 1'b1) break;
    end
  endtask

  // Offer, take, latch, flag and clear for one winner
  task automatic fire(input logic [79:0] m, input int k,
                      input logic [6:0] v, input logic [3:0] l,
                      input logic [23:0] base);
    logic [11:0] fa;
    fa = 12'h010 + 12'(k / 16 * 4);
    pulse(m);
    wait_req(8);
    chk(cpu_req.valid, 1);
    chk(cpu_req.vector, v);
    chk(cpu_req.level, l);
    chk(cpu_req.fetch_addr, base + {v, 1'b0});
    repeat (8) @(negedge pclk);
    rdchk(12'h0b0, {21'h0, l, v});
    apb(1'b0, fa, 32'h0);
    chk(rd[k % 16], 1);
    apb(1'b1, fa, 32'h0);
    repeat (40) @(posedge pclk);
    apb(1'b1, 12'h0c0, 32'h0);
  endtask

  task automatic t_reset();
    logic [11:0] r [8] = '{12'h000, 12'h004, 12'h010, 12'h030,
                           12'h050, 12'h0b0, 12'h0c0, 12'h0c4};
    foreach (r[i]) rdchk(r[i], 32'h0);
    chk(cpu_req.valid, 0);
    $display("t_reset done");
  endtask

  task automatic t_arb();
    apb(1'b1, 12'h030, 32'h3);
    apb(1'b1, 12'h050, 32'h33);
    fire(80'h3, 0, 7'h08, 4'h3, 24'h000004);
    apb(1'b1, 12'h050, 32'h53);
    fire(80'h3, 1, 7'h09, 4'h5, 24'h000004);
    $display("t_arb done");
  endtask

  task automatic t_alt();
    apb(1'b1, 12'h004, 32'h8000);
    rdchk(12'h0cc, 32'h1);
    apb(1'b1, 12'h040, 32'h8000);
    apb(1'b1, 12'h09c, 32'h2000);
    fire(80'h1 << 79, 79, 7'h57, 4'h2, 24'h000104);
    apb(1'b1, 12'h004, 32'h0);
    $display("t_alt done");
  endtask

  task automatic t_block();
    apb(1'b1, 12'h0c0, 32'he0);
    apb(1'b1, 12'h050, 32'h7);
    pulse(80'h1);
    wait_req(10);
    chk(cpu_req.valid, 0);
    rdchk(12'h0c0, 32'he0);
    apb(1'b1, 12'h030, 32'h0);
    apb(1'b1, 12'h0c0, 32'h0);
    wait_req(10);
    chk(cpu_req.valid, 0);
    apb(1'b1, 12'h010, 32'h0);
    $display("t_block done");
  endtask

  task automatic t_regs();
    apb(1'b1, 12'h000, 32'h8000);
    apb(1'b1, 12'h0c0, 32'h60);
    rdchk(12'h0c0, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h0c4, 32'h8);
    rdchk(12'h0c4, 32'h0);
    rdchk(12'h0d0, 32'h0);
    chk(err, 1);
    @(posedge pclk);
    trap_event <= 7'h01;
    @(posedge pclk);
    trap_event <= 7'h00;
    rdchk(12'h000, 32'h2);
    apb(1'b1, 12'h000, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_ext();
    @(posedge pclk);
    ext_pin <= 3'h1;
    rdchk(12'h010, 32'h1);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h004, 32'h1);
    @(posedge pclk);
    ext_pin <= 3'h0;
    rdchk(12'h010, 32'h1);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    $display("t_ext done");
  endtask

  task automatic t_nest();
    apb(1'b1, 12'h030, 32'h3);
    apb(1'b1, 12'h050, 32'h52);
    pulse(80'h1);
    wait_req(8);
    chk(cpu_req.vector, 7'h08);
    repeat (8) @(negedge pclk);
    pulse(80'h2);
    wait_req(8);
    chk(cpu_req.valid, 1);
    chk(cpu_req.vector, 7'h09);
    repeat (80) @(posedge pclk);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h0c0, 32'h0);
    apb(1'b1, 12'h000, 32'h8000);
    pulse(80'h1);
    wait_req(8);
    repeat (8) @(negedge pclk);
    pulse(80'h2);
    wait_req(8);
    chk(cpu_req.valid, 0);
    repeat (80) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h0c0, 32'h0);
    apb(1'b1, 12'h030, 32'h0);
    $display("t_nest done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_arb();
    t_alt();
    t_block();
    t_regs();
    t_ext();
    t_nest();
    final_report();
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
endmodule // testbench
